// file: rtl/pbap_pkg.sv
// Shared constants and types of the bus grant priority arbiter.
package pbap_pkg;
	localparam int NUM_REQ = 5;
	localparam int IDX_W = 3;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] FAIR_LEN = 3'h5;
	localparam logic [3:0] ALT_LEN = 4'h8;
	localparam logic [IDX_W-1:0] IDX_INTERNAL = 3'h0;
	localparam logic [IDX_W-1:0] IDX_EXT0 = 3'h1;
	localparam logic [IDX_W-1:0] IDX_EXT3 = 3'h4;
	localparam int CFG_ADDR_W = 9;
	localparam logic [CFG_ADDR_W-1:0] PRI_CTRL_OFF = 9'h142;
	localparam int SCHEME_LSB = 8;
	localparam int TAKEAWAY_BIT = 10;
	localparam int OWNER_LSB = 12;
	localparam int OWNER_VALID_BIT = 15;
	localparam logic [15:0] PRI_CTRL_RESET = 16'h0000;

	typedef enum logic [1:0] {
		PBAP_FAIR = 2'b00,
		PBAP_ALT_EXT0 = 2'b01,
		PBAP_ALT_INT = 2'b10,
		PBAP_UNDEF = 2'b11
	} pbap_scheme_t;
endpackage : pbap_pkg

// file: rtl/pbap_pick_if.sv
// Carrier between the arbiter core and its candidate picker.
`timescale 1ns/100ps
interface pbap_pick_if;
	import pbap_pkg::*;
	logic [NUM_REQ-1:0] req;
	pbap_scheme_t scheme;
	logic [SLOT_W-1:0] ptr;
	logic found;
	logic [IDX_W-1:0] win;
	logic [SLOT_W-1:0] nxt;
	modport core (output req, output scheme, output ptr, input found, input win, input nxt);
	modport picker (input req, input scheme, input ptr, output found, output win, output nxt);
endinterface : pbap_pick_if

// file: rtl/pbap_picker.sv
// Walks the rotation sequence from the current slot to the first active requestor.
`timescale 1ns/100ps
module pbap_picker
	import pbap_pkg::*;
(
	pbap_pick_if.picker pk
);
	// Requestor index held by a given slot of the sequence for each scheme.
	function automatic logic [IDX_W-1:0] slot_owner(input pbap_scheme_t s,
		input logic [SLOT_W-1:0] slot);
		logic [IDX_W-1:0] odd_owner;
		odd_owner = (slot[2:1] == 2'h0) ? IDX_INTERNAL : {1'b0, slot[2:1]} + IDX_EXT0;
		unique case (s)
			PBAP_ALT_EXT0: slot_owner = slot[0] ? odd_owner : IDX_EXT0;
			PBAP_ALT_INT: slot_owner = slot[0] ? ((slot[2:1] == 2'h0) ? IDX_EXT0 :
				{1'b0, slot[2:1]} + IDX_EXT0) : IDX_INTERNAL;
			default: slot_owner = slot;
		endcase
	endfunction : slot_owner

	always_comb begin
		logic [3:0] len;
		logic [3:0] idx;
		logic [IDX_W-1:0] who;
		len = 4'h0;
		idx = 4'h0;
		who = IDX_INTERNAL;
		pk.found = 1'b0;
		pk.win = IDX_INTERNAL;
		pk.nxt = pk.ptr;
		len = (pk.scheme == PBAP_ALT_EXT0 || pk.scheme == PBAP_ALT_INT) ? ALT_LEN :
			{1'b0, FAIR_LEN};
		for (int i = 0; i < 8; i++) begin
			idx = {1'b0, pk.ptr} + 4'(i);
			if (idx >= len) begin
				idx = idx - len;
			end
			who = slot_owner(pk.scheme, idx[SLOT_W-1:0]);
			if (4'(i) < len && !pk.found && pk.req[who]) begin
				pk.found = 1'b1;
				pk.win = who;
				pk.nxt = (idx + 4'h1 >= len) ? 3'h0 : 3'(idx + 4'h1);
			end
		end
	end
endmodule : pbap_picker

// file: rtl/pbap_arbiter.sv
// Bus grant arbiter with rotating priority schemes and optional grant take-away.
// Function
// - Scheme 00 gives fair round-robin rotation.
// - Fair order: internal, 0, 1, 2, 3.
// - Idle requestors are skipped in rotation.
// - Scheme 01 alternates requestor 0 with others.
// - Scheme 10 alternates internal with others.
// - Take-away off: grant held until release.
// - Take-away on: other request removes grant.
// - Priority control register is software read/write.
`timescale 1ns/100ps
module pbap_arbiter
	import pbap_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic INT_REQ,
	input wire logic [3:0] REQ_N,
	output logic INT_GNT,
	output logic [3:0] GNT_N,
	input wire logic CFG_WE,
	input wire logic [CFG_ADDR_W-1:0] CFG_ADDR,
	input wire logic [15:0] CFG_WDATA,
	output logic [15:0] CFG_RDATA
);
	pbap_pick_if pk ();
	pbap_scheme_t scheme_q;
	logic takeaway_q;
	logic [SLOT_W-1:0] ptr_q;
	logic [IDX_W-1:0] last_q;
	logic [NUM_REQ-1:0] req;
	logic [NUM_REQ-1:0] gnt;
	logic owner_req;
	logic other_req;
	logic cfg_hit;
	logic scheme_change;

	assign req = {~REQ_N, INT_REQ};
	assign gnt = {~GNT_N, INT_GNT};
	assign owner_req = |(gnt & req);
	assign other_req = |(req & ~gnt);
	assign cfg_hit = CFG_WE && (CFG_ADDR == PRI_CTRL_OFF);
	assign scheme_change = cfg_hit && (CFG_WDATA[SCHEME_LSB+1:SCHEME_LSB] != scheme_q);

	assign pk.req = req;
	assign pk.scheme = scheme_q;
	assign pk.ptr = ptr_q;

	pbap_picker u_picker (
		.pk(pk.picker)
	);

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			scheme_q <= pbap_scheme_t'(PRI_CTRL_RESET[SCHEME_LSB+1:SCHEME_LSB]);
			takeaway_q <= PRI_CTRL_RESET[TAKEAWAY_BIT];
		end else if (cfg_hit) begin
			scheme_q <= pbap_scheme_t'(CFG_WDATA[SCHEME_LSB+1:SCHEME_LSB]);
			takeaway_q <= CFG_WDATA[TAKEAWAY_BIT];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CFG_RDATA <= 16'h0000;
		end else begin
			CFG_RDATA <= 16'h0000;
			if (CFG_ADDR == PRI_CTRL_OFF) begin
				CFG_RDATA[SCHEME_LSB+1:SCHEME_LSB] <= scheme_q;
				CFG_RDATA[TAKEAWAY_BIT] <= takeaway_q;
				CFG_RDATA[OWNER_LSB+IDX_W-1:OWNER_LSB] <= last_q;
				CFG_RDATA[OWNER_VALID_BIT] <= |gnt;
			end
		end
	end

	// Grants change only between ownerships, so a release costs one idle cycle.
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			INT_GNT <= 1'b0;
			GNT_N <= 4'hF;
		end else if (|gnt) begin
			if (!owner_req || (takeaway_q && other_req)) begin
				INT_GNT <= 1'b0;
				GNT_N <= 4'hF;
			end
		end else if (pk.found) begin
			INT_GNT <= (pk.win == IDX_INTERNAL);
			for (int i = 0; i < 4; i++) begin
				GNT_N[i] <= (pk.win != 3'(i + 1));
			end
		end
	end

	// A scheme switch restarts its sequence, since old slot numbers mean nothing.
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ptr_q <= 3'h0;
			last_q <= IDX_EXT3;
		end else if (scheme_change) begin
			ptr_q <= 3'h0;
			last_q <= IDX_EXT3;
		end else if (!(|gnt) && pk.found) begin
			ptr_q <= pk.nxt;
			last_q <= pk.win;
		end
	end

	property p_onehot_grant;
		@(posedge REF_CLK) disable iff (SYS_RST) $onehot0(gnt);
	endproperty
	a_onehot_grant: assert property (p_onehot_grant) else $error("more than one grant");

	property p_idle_skip;
		@(posedge REF_CLK) disable iff (SYS_RST) (gnt == 5'h00 && req != 5'h00) |=> gnt != 5'h00;
	endproperty
	a_idle_skip: assert property (p_idle_skip) else $error("active request left ungranted");

	property p_reset_fair;
		@(posedge REF_CLK) $past(SYS_RST) && !SYS_RST |-> scheme_q == PBAP_FAIR && !takeaway_q;
	endproperty
	a_reset_fair: assert property (p_reset_fair) else $error("scheme not fair after reset");

	property p_fair_order;
		@(posedge REF_CLK) disable iff (SYS_RST)
		((scheme_q == PBAP_FAIR || scheme_q == PBAP_UNDEF) && !CFG_WE && gnt == 5'h00
			&& req[1] && last_q == IDX_INTERNAL) |=> gnt == 5'h02;
	endproperty
	a_fair_order: assert property (p_fair_order) else $error("fair rotation out of order");

	property p_fair_wrap;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(scheme_q == PBAP_FAIR && !CFG_WE && gnt == 5'h00 && req[0]
			&& last_q == IDX_EXT3) |=> gnt == 5'h01;
	endproperty
	a_fair_wrap: assert property (p_fair_wrap) else $error("fair rotation did not wrap");

	property p_alt_ext0;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(scheme_q == PBAP_ALT_EXT0 && !CFG_WE && gnt == 5'h00 && req[1]
			&& last_q != IDX_EXT0) |=> gnt == 5'h02;
	endproperty
	a_alt_ext0: assert property (p_alt_ext0) else $error("requestor 0 missed its slot");

	property p_alt_int;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(scheme_q == PBAP_ALT_INT && !CFG_WE && gnt == 5'h00 && req[0]
			&& last_q != IDX_INTERNAL) |=> gnt == 5'h01;
	endproperty
	a_alt_int: assert property (p_alt_int) else $error("internal request missed its slot");

	property p_hold_grant;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(!takeaway_q && gnt != 5'h00 && owner_req) |=> gnt == $past(gnt);
	endproperty
	a_hold_grant: assert property (p_hold_grant) else $error("grant dropped while requested");

	property p_takeaway;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(takeaway_q && gnt != 5'h00 && other_req) |=> gnt == 5'h00;
	endproperty
	a_takeaway: assert property (p_takeaway) else $error("grant not taken away");

	property p_readback;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(cfg_hit ##1 (CFG_ADDR == PRI_CTRL_OFF && !CFG_WE)) |=>
			CFG_RDATA[TAKEAWAY_BIT:SCHEME_LSB] == $past(CFG_WDATA[TAKEAWAY_BIT:SCHEME_LSB], 2);
	endproperty
	a_readback: assert property (p_readback) else $error("control register readback wrong");

	c_ext0_grant: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		scheme_q == PBAP_ALT_EXT0 && gnt == 5'h02);
	c_int_grant: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		scheme_q == PBAP_ALT_INT && gnt == 5'h01);
	c_takeaway: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		takeaway_q && gnt != 5'h00 && other_req ##1 gnt == 5'h00);
	c_fair_ext3: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
		scheme_q == PBAP_FAIR && gnt == 5'h10);
endmodule : pbap_arbiter

// file: verif/pbap_req_model.sv
// Requestor model: each enabled master asks, holds its grant a while, then lets go.
`timescale 1ns/100ps
module pbap_req_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] en,
	input wire logic [7:0] hold,
	input wire logic INT_GNT,
	input wire logic [3:0] GNT_N,
	output logic INT_REQ,
	output logic [3:0] REQ_N
);
	logic [4:0] req_q;
	logic [7:0] cnt_q [5];
	wire logic [4:0] gnt = {~GNT_N, INT_GNT};
	assign INT_REQ = req_q[0];
	assign REQ_N = ~req_q[4:1];
	// A master whose grant is taken away keeps asking, so it rejoins the rotation.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 5; i++) begin
			if (rst || !gnt[i]) begin
				cnt_q[i] <= 8'h00;
				req_q[i] <= !rst && en[i];
			end else begin
				cnt_q[i] <= cnt_q[i] + 8'h01;
				if (cnt_q[i] + 8'h01 >= hold) req_q[i] <= 1'b0;
			end
		end
	end
endmodule : pbap_req_model

// file: verif/pbap_arbiter_tb_top.sv
// Self-checking bench for the priority arbiter driven by a requestor model.
`timescale 1ns/100ps
module pbap_arbiter_tb_top;
	import pbap_pkg::*;
	logic REF_CLK = 1'b0, SYS_RST = 1'b1, CFG_WE = 1'b0, run = 1'b0, tk = 1'b0, act_q = 1'b0;
	logic INT_REQ, INT_GNT;
	logic [3:0] REQ_N, GNT_N;
	logic [CFG_ADDR_W-1:0] CFG_ADDR = PRI_CTRL_OFF;
	logic [15:0] CFG_WDATA = 16'h0000, CFG_RDATA, rv;
	logic [4:0] en = 5'h00, m;
	logic [7:0] hold = 8'h04;
	logic [31:0] s = 32'h0;
	logic [2:0] exp_q [$];
	int mismatches = 0, samples_checked = 0, glen = 0, j = 0;
	always #25 REF_CLK = ~REF_CLK;
	pbap_arbiter u_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INT_REQ(INT_REQ),
		.REQ_N(REQ_N), .INT_GNT(INT_GNT), .GNT_N(GNT_N), .CFG_WE(CFG_WE),
		.CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA));
	pbap_req_model u_req (.clk(REF_CLK), .rst(SYS_RST), .en(en), .hold(hold),
		.INT_GNT(INT_GNT), .GNT_N(GNT_N), .INT_REQ(INT_REQ), .REQ_N(REQ_N));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	task wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge REF_CLK);
		CFG_WE <= 1'b1;
		CFG_ADDR <= a;
		CFG_WDATA <= d;
		@(posedge REF_CLK);
		CFG_WE <= 1'b0;
		CFG_WDATA <= 16'($urandom);
	endtask : wr
	task rd(input logic [8:0] a);
		@(posedge REF_CLK);
		CFG_ADDR <= a;
		repeat (2) @(posedge REF_CLK);
		#1 rv = CFG_RDATA;
	endtask : rd
	// Grants are looked at on the falling edge, well away from the edge that launches them.
	always @(negedge REF_CLK) begin : watch
		logic act;
		logic [2:0] idx;
		act = INT_GNT === 1'b1 || GNT_N !== 4'hF;
		idx = 3'h0;
		for (int i = 3; i >= 0; i--) if (GNT_N[i] === 1'b0) idx = 3'(i + 1);
		if (act && !act_q && exp_q.size() > 0) check("winner", 16'(idx), 16'(exp_q.pop_front()));
		if (!act && act_q && run) check("held", 16'(glen >= hold), 16'(!tk));
		glen = act ? glen + 1 : 0;
		act_q = act;
	end
	task run_test(input int t, input logic [1:0] sc, input logic k, input logic [4:0] mk,
		input logic [31:0] seq, input int n);
		hold <= k ? 8'h14 : 8'(2 + $urandom % 6);
		wr(PRI_CTRL_OFF, (16'(sc) << SCHEME_LSB) | (16'(k) << TAKEAWAY_BIT));
		rd(PRI_CTRL_OFF);
		check("setting", 16'(rv[10:8]), 16'({k, sc}));
		for (int i = 0; i < n; i++) exp_q.push_back(seq[28 - 4 * i +: 3]);
		tk = k;
		run = 1'b1;
		en <= mk;
		for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge REF_CLK);
		check("pending", 16'(exp_q.size()), 16'h0000);
		run = 1'b0;
		exp_q.delete();
		en <= 5'h00;
		repeat (40) @(posedge REF_CLK);
		$display("test %0d done", t);
	endtask : run_test
	initial begin
		void'($urandom(32'h6FC1));
		repeat (4) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		rd(PRI_CTRL_OFF);
		check("reset", 16'(rv[10:8]), 16'h0000);
		check("status", 16'(rv[15:12]), 16'h0004);
		wr(PRI_CTRL_OFF, 16'h0500);
		rd(PRI_CTRL_OFF);
		check("write", 16'(rv[10:8]), 16'h0005);
		wr(9'h140, 16'h0200);
		rd(PRI_CTRL_OFF);
		check("ignored", 16'(rv[10:8]), 16'h0005);
		rd(9'h140);
		check("unmapped", rv, 16'h0000);
		$display("test 0 done");
		run_test(1, 2'b00, 1'b0, 5'h1F, 32'h01234012, 8);
		run_test(2, 2'b01, 1'b0, 5'h1F, 32'h10121314, 8);
		run_test(3, 2'b10, 1'b1, 5'h1F, 32'h01020304, 8);
		m = 5'($urandom % 31) + 5'h01;
		for (int i = 0; j < 6; i++) if (m[i % 5]) begin
			s[28 - 4 * j +: 3] = 3'(i % 5);
			j++;
		end
		run_test(4, 2'b11, 1'b0, m, s, 6);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge REF_CLK);
		mismatches++;
		conclude();
	end
endmodule : pbap_arbiter_tb_top
